// >>> design/cie_pkg.sv
package cie_pkg;

  // ******************************************************
  // Register indices; the byte address is four times the index.
  // ******************************************************
  localparam logic [7:0] REG_STACK_PTR  = 8'h81;
  localparam logic [7:0] REG_DATA_POINTER_LOW   = 8'h82;
  localparam logic [7:0] REG_DATA_POINTER_HIGH  = 8'h83;
  localparam logic [7:0] REG_IDLE_SEL   = 8'h87;
  localparam logic [7:0] REG_STATUS     = 8'hD0;
  localparam logic [7:0] REG_MAIN_WORK  = 8'hE0;
  localparam logic [7:0] REG_MUL_AUX    = 8'hF0;

  localparam logic [7:0] RST_STACK_PTR  = 8'h07;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [15:0] RST_PC        = 16'h0000;

  // ******************************************************
  // Status register fields and the idle select bit.
  // ******************************************************
  localparam int unsigned FLAG_CY       = 7;
  localparam int unsigned FLAG_AC       = 6;
  localparam int unsigned FLAG_OV       = 2;
  localparam int unsigned FLAG_P        = 0;
  localparam int unsigned IDLE_BIT      = 0;

  // ******************************************************
  // Decimal adjust constants.
  // ******************************************************
  localparam logic [3:0] DA_NIBBLE_MAX  = 4'h9;
  localparam logic [8:0] DA_LOW_ADJ     = 9'h006;
  localparam logic [8:0] DA_HIGH_ADJ    = 9'h060;

  // ******************************************************
  // Operations and their costs.
  // ******************************************************
  typedef enum logic [4:0] {
    OP_MUL       = 5'h00,
    OP_DIV       = 5'h01,
    OP_DA        = 5'h02,
    OP_ANL_A     = 5'h03,
    OP_ANL_DIR_A = 5'h04,
    OP_ANL_DIR_I = 5'h05,
    OP_ORL_A     = 5'h06,
    OP_ORL_DIR_A = 5'h07,
    OP_ORL_DIR_I = 5'h08,
    OP_XRL_A     = 5'h09,
    OP_XRL_DIR_A = 5'h0A,
    OP_XRL_DIR_I = 5'h0B,
    OP_RL        = 5'h0C,
    OP_RR        = 5'h0D,
    OP_RLC       = 5'h0E,
    OP_RRC       = 5'h0F,
    OP_JMP_ADPTR = 5'h10,
    OP_JBC       = 5'h11,
    OP_DECREMENT_BRANCH_NONZERO      = 5'h12,
    OP_ANL_CNBIT = 5'h13,
    OP_ORL_CNBIT = 5'h14
  } cie_op_t;

  function automatic logic [2:0] op_cycles(input cie_op_t op);
    case (op)
      OP_MUL, OP_DIV: op_cycles = 3'h4;
      OP_ANL_DIR_I, OP_ORL_DIR_I, OP_XRL_DIR_I, OP_JMP_ADPTR, OP_JBC, OP_DECREMENT_BRANCH_NONZERO,
      OP_ANL_CNBIT, OP_ORL_CNBIT: op_cycles = 3'h2;
      default: op_cycles = 3'h1;
    endcase
  endfunction

  function automatic logic [1:0] op_bytes(input cie_op_t op, input logic wide);
    case (op)
      OP_ANL_DIR_I, OP_ORL_DIR_I, OP_XRL_DIR_I, OP_JBC: op_bytes = 2'h3;
      OP_ANL_DIR_A, OP_ORL_DIR_A, OP_XRL_DIR_A, OP_DECREMENT_BRANCH_NONZERO, OP_ANL_CNBIT, OP_ORL_CNBIT: op_bytes = 2'h2;
      OP_ANL_A, OP_ORL_A, OP_XRL_A: op_bytes = wide ? 2'h2 : 2'h1;
      default: op_bytes = 2'h1;
    endcase
  endfunction

endpackage

// >>> design/cie_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cie_alu_if;
  import cie_pkg::*;
  cie_op_t    op;
  logic [7:0] a;
  logic [7:0] b;
  logic       cy;
  logic       ac;
  logic [7:0] lg_res;
  logic       lg_cy;
  logic [7:0] mul_lo;
  logic [7:0] mul_hi;
  logic       mul_ov;
  logic [7:0] div_q;
  logic [7:0] div_r;
  logic       div_ov;
  modport core   (output op, a, b, cy, ac, input lg_res, lg_cy, mul_lo, mul_hi, mul_ov, div_q, div_r, div_ov);
  modport logic_u(input op, a, b, cy, ac, output lg_res, lg_cy);
  modport muldiv (input a, b, output mul_lo, mul_hi, mul_ov, div_q, div_r, div_ov);
endinterface
`default_nettype wire

// >>> design/cie_muldiv.sv
`timescale 1ns/1ps
`default_nettype none
module cie_muldiv
  import cie_pkg::*;
(
  cie_alu_if.muldiv alu
);
  logic [15:0] product;

  // ******************************************************
  // Unsigned multiply and divide.
  // ******************************************************
  assign product    = alu.a * alu.b;
  assign alu.mul_lo = product[7:0];
  assign alu.mul_hi = product[15:8];
  assign alu.mul_ov = (product[15:8] != RST_ZERO);
  // A zero divisor leaves the operands as they were and only raises overflow.
  assign alu.div_ov = (alu.b == RST_ZERO);
  assign alu.div_q  = alu.div_ov ? alu.a : alu.a / alu.b;
  assign alu.div_r  = alu.div_ov ? alu.b : alu.a % alu.b;
endmodule
`default_nettype wire

// >>> design/cie_logic_unit.sv
`timescale 1ns/1ps
`default_nettype none
module cie_logic_unit
  import cie_pkg::*;
(
  cie_alu_if.logic_u alu
);
  logic [8:0] da_step1;
  logic [8:0] da_step2;

  // ******************************************************
  // Decimal adjust in two steps.
  // ******************************************************
  always_comb begin
    da_step1 = {1'b0, alu.a};
    if ((alu.a[3:0] > DA_NIBBLE_MAX) || alu.ac) begin
      da_step1 = {1'b0, alu.a} + DA_LOW_ADJ;
    end
    da_step2 = da_step1;
    if ((da_step1[7:4] > DA_NIBBLE_MAX) || alu.cy || da_step1[8]) begin
      da_step2 = da_step1 + DA_HIGH_ADJ;
    end
  end

  // ******************************************************
  // Logic, rotate and carry-bit operations.
  // ******************************************************
  always_comb begin
    alu.lg_res = alu.a;
    alu.lg_cy  = alu.cy;
    case (alu.op)
      OP_DA: begin
        alu.lg_res = da_step2[7:0];
        alu.lg_cy  = alu.cy | da_step2[8];
      end
      OP_ANL_A, OP_ANL_DIR_A, OP_ANL_DIR_I: alu.lg_res = alu.a & alu.b;
      OP_ORL_A, OP_ORL_DIR_A, OP_ORL_DIR_I: alu.lg_res = alu.a | alu.b;
      OP_XRL_A, OP_XRL_DIR_A, OP_XRL_DIR_I: alu.lg_res = alu.a ^ alu.b;
      OP_RL: alu.lg_res = {alu.a[6:0], alu.a[7]};
      OP_RR: alu.lg_res = {alu.a[0], alu.a[7:1]};
      OP_RLC: begin
        alu.lg_res = {alu.a[6:0], alu.cy};
        alu.lg_cy  = alu.a[7];
      end
      OP_RRC: begin
        alu.lg_res = {alu.cy, alu.a[7:1]};
        alu.lg_cy  = alu.a[0];
      end
      OP_ANL_CNBIT: alu.lg_cy = alu.cy & ~alu.b[0];
      OP_ORL_CNBIT: alu.lg_cy = alu.cy | ~alu.b[0];
      default: begin
        alu.lg_res = alu.a;
        alu.lg_cy  = alu.cy;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> design/cie_core.sv
// How it works
// - Multiply A by B, low A, high B.
// - Divide A by B, remainder B, overflow.
// - Decimal adjust adds 06H then 60H.
// - AND into A updates parity only.
// - OR/XOR to direct writes back, flags untouched.
// - XOR into A updates parity, one cycle.
// - Plain rotates ignore carry and flags.
// - Carry rotates use carry as ninth bit.
// - Indirect jump loads A plus data pointer.
// - Bit test clears set bit and branches.
// - Decrement register, branch when nonzero.
// - Carry ORed with inverted bit.
// - Data pointer bytes readable, writable, reset zero.
// - Idle select register resets to zero.
`timescale 1ns/1ps
`default_nettype none
module cie_core
  import cie_pkg::*;
#(
  parameter int unsigned ADDR_W = 10
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic              exec_valid_i,
  input  wire cie_op_t           exec_op_i,
  input  wire logic [7:0]        exec_data_i,
  input  wire logic [7:0]        exec_aux_i,
  input  wire logic              exec_wide_i,
  output logic                   exec_ready_o,
  output logic                   exec_done_o,
  output logic                   wr_valid_o,
  output logic      [7:0]        wr_data_o,
  output logic      [15:0]       pc_o,
  output logic                   carry_flag_o,
  output logic                   parity_o,
  output logic                   idle_o
);

  // ******************************************************
  // State and storage.
  // ******************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cie_state_t;

  cie_state_t  state;
  cie_op_t     op_q;
  logic [7:0]  data_q;
  logic [7:0]  aux_q;
  logic        wide_q;
  logic [2:0]  cnt;
  logic        retire;
  logic [7:0]  main_working_reg;
  logic [7:0]  multiply_aux_reg;
  logic [7:0]  stack_pointer;
  logic [7:0]  data_pointer_low;
  logic [7:0]  data_pointer_high;
  logic [7:0]  idle_select;
  logic        carry_flag;
  logic        aux_carry_flag;
  logic        overflow_flag;
  logic        parity;
  logic [7:0]  dec_val;
  logic [15:0] rel_ext;
  logic [15:0] seq_pc;
  logic [15:0] next_pc;
  logic [7:0]  wb_index;
  logic        wb_hit;
  logic        wb_wr;
  logic [7:0]  next_rdata;
  logic        acc_we;
  logic [7:0]  acc_val;

  cie_alu_if alu ();

  cie_muldiv u_muldiv (
    .alu (alu)
  );

  cie_logic_unit u_logic (
    .alu (alu)
  );

  assign alu.op = op_q;
  assign alu.cy = carry_flag;
  assign alu.ac = aux_carry_flag;

  // ******************************************************
  // Operand steering.
  // ******************************************************
  always_comb begin
    alu.a = main_working_reg;
    alu.b = data_q;
    case (op_q)
      OP_MUL, OP_DIV: alu.b = multiply_aux_reg;
      OP_ANL_DIR_A, OP_ORL_DIR_A, OP_XRL_DIR_A: begin
        alu.a = data_q;
        alu.b = main_working_reg;
      end
      OP_ANL_DIR_I, OP_ORL_DIR_I, OP_XRL_DIR_I: begin
        alu.a = data_q;
        alu.b = aux_q;
      end
      default: begin
        alu.a = main_working_reg;
        alu.b = data_q;
      end
    endcase
  end

  // ******************************************************
  // Issue and cycle counting.
  // ******************************************************
  // An operation retires on the edge its cycle budget runs out, and
  // a new one is only taken after that edge.
  assign retire = (state == ST_EXEC) && (cnt == 3'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state        <= ST_IDLE;
      cnt          <= 3'h0;
      exec_ready_o <= 1'b0;
      op_q         <= OP_DA;
      data_q       <= RST_ZERO;
      aux_q        <= RST_ZERO;
      wide_q       <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          exec_ready_o <= 1'b1;
          if (exec_valid_i && exec_ready_o) begin
            state        <= ST_EXEC;
            cnt          <= op_cycles(exec_op_i);
            exec_ready_o <= 1'b0;
            op_q         <= exec_op_i;
            data_q       <= exec_data_i;
            aux_q        <= exec_aux_i;
            wide_q       <= exec_wide_i;
          end
        end
        ST_EXEC: begin
          cnt <= cnt - 3'h1;
          if (retire) begin
            state        <= ST_IDLE;
            exec_ready_o <= 1'b1;
          end
        end
        default: begin
          state        <= ST_IDLE;
          exec_ready_o <= 1'b0;
        end
      endcase
    end
  end

  // ******************************************************
  // Program counter.
  // ******************************************************
  assign dec_val = data_q - 8'h01;
  assign rel_ext = {{8{aux_q[7]}}, aux_q};
  assign seq_pc  = pc_o + {14'h0000, op_bytes(op_q, wide_q)};

  always_comb begin
    next_pc = seq_pc;
    case (op_q)
      OP_JMP_ADPTR: next_pc = {data_pointer_high, data_pointer_low} + {8'h00, main_working_reg};
      OP_JBC: begin
        if (data_q[0]) begin
          next_pc = seq_pc + rel_ext;
        end
      end
      OP_DECREMENT_BRANCH_NONZERO: begin
        if (dec_val != RST_ZERO) begin
          next_pc = seq_pc + rel_ext;
        end
      end
      default: next_pc = seq_pc;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_o <= RST_PC;
    end else if (retire) begin
      pc_o <= next_pc;
    end
  end

  // ******************************************************
  // Write-back to direct locations, registers and bits.
  // ******************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_valid_o  <= 1'b0;
      wr_data_o   <= RST_ZERO;
      exec_done_o <= 1'b0;
    end else begin
      exec_done_o <= retire;
      wr_valid_o  <= 1'b0;
      if (retire) begin
        case (op_q)
          OP_ANL_DIR_A, OP_ANL_DIR_I, OP_ORL_DIR_A, OP_ORL_DIR_I, OP_XRL_DIR_A, OP_XRL_DIR_I: begin
            wr_valid_o <= 1'b1;
            wr_data_o  <= alu.lg_res;
          end
          OP_JBC: begin
            wr_valid_o <= data_q[0];
            wr_data_o  <= RST_ZERO;
          end
          OP_DECREMENT_BRANCH_NONZERO: begin
            wr_valid_o <= 1'b1;
            wr_data_o  <= dec_val;
          end
          default: wr_valid_o <= 1'b0;
        endcase
      end
    end
  end

  // ******************************************************
  // Accumulator and auxiliary register.
  // ******************************************************
  always_comb begin
    acc_we  = 1'b0;
    acc_val = alu.lg_res;
    case (op_q)
      OP_MUL: begin
        acc_we  = 1'b1;
        acc_val = alu.mul_lo;
      end
      OP_DIV: begin
        acc_we  = 1'b1;
        acc_val = alu.div_q;
      end
      OP_DA, OP_ANL_A, OP_ORL_A, OP_XRL_A, OP_RL, OP_RR, OP_RLC, OP_RRC: acc_we = 1'b1;
      default: acc_we = 1'b0;
    endcase
  end

  // Execution wins over a bus write that lands on the same edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_working_reg <= RST_ZERO;
      multiply_aux_reg <= RST_ZERO;
    end else begin
      if (retire && acc_we) begin
        main_working_reg <= acc_val;
      end else if (wb_wr && wb_index == REG_MAIN_WORK) begin
        main_working_reg <= dat_i[7:0];
      end
      if (retire && op_q == OP_MUL) begin
        multiply_aux_reg <= alu.mul_hi;
      end else if (retire && op_q == OP_DIV) begin
        multiply_aux_reg <= alu.div_r;
      end else if (wb_wr && wb_index == REG_MUL_AUX) begin
        multiply_aux_reg <= dat_i[7:0];
      end
    end
  end

  // ******************************************************
  // Status flags.
  // ******************************************************
  assign parity = ^main_working_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry_flag     <= 1'b0;
      aux_carry_flag <= 1'b0;
      overflow_flag  <= 1'b0;
    end else if (retire) begin
      case (op_q)
        OP_MUL: begin
          carry_flag    <= 1'b0;
          overflow_flag <= alu.mul_ov;
        end
        OP_DIV: begin
          carry_flag    <= 1'b0;
          overflow_flag <= alu.div_ov;
        end
        OP_DA, OP_RLC, OP_RRC, OP_ANL_CNBIT, OP_ORL_CNBIT: carry_flag <= alu.lg_cy;
        default: carry_flag <= carry_flag;
      endcase
    end else if (wb_wr && wb_index == REG_STATUS) begin
      carry_flag     <= dat_i[FLAG_CY];
      aux_carry_flag <= dat_i[FLAG_AC];
      overflow_flag  <= dat_i[FLAG_OV];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry_flag_o <= 1'b0;
      parity_o     <= 1'b0;
      idle_o       <= 1'b0;
    end else begin
      carry_flag_o <= carry_flag;
      parity_o     <= parity;
      idle_o       <= idle_select[IDLE_BIT];
    end
  end

  // ******************************************************
  // Wishbone slave.
  // ******************************************************
  assign wb_index = adr_i[ADDR_W-1:2];
  assign wb_hit   = cyc_i && stb_i && !ack_o;
  assign wb_wr    = wb_hit && we_i && sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_pointer     <= RST_STACK_PTR;
      data_pointer_low  <= RST_ZERO;
      data_pointer_high <= RST_ZERO;
      idle_select       <= RST_ZERO;
    end else if (wb_wr) begin
      if (wb_index == REG_STACK_PTR) begin
        stack_pointer <= dat_i[7:0];
      end else if (wb_index == REG_DATA_POINTER_LOW) begin
        data_pointer_low <= dat_i[7:0];
      end else if (wb_index == REG_DATA_POINTER_HIGH) begin
        data_pointer_high <= dat_i[7:0];
      end else if (wb_index == REG_IDLE_SEL) begin
        idle_select <= dat_i[7:0];
      end
    end
  end

  always_comb begin
    next_rdata = RST_ZERO;
    if (wb_index == REG_STACK_PTR) begin
      next_rdata = stack_pointer;
    end else if (wb_index == REG_DATA_POINTER_LOW) begin
      next_rdata = data_pointer_low;
    end else if (wb_index == REG_DATA_POINTER_HIGH) begin
      next_rdata = data_pointer_high;
    end else if (wb_index == REG_IDLE_SEL) begin
      next_rdata = idle_select;
    end else if (wb_index == REG_STATUS) begin
      next_rdata[FLAG_CY] = carry_flag;
      next_rdata[FLAG_AC] = aux_carry_flag;
      next_rdata[FLAG_OV] = overflow_flag;
      next_rdata[FLAG_P]  = parity;
    end else if (wb_index == REG_MAIN_WORK) begin
      next_rdata = main_working_reg;
    end else if (wb_index == REG_MUL_AUX) begin
      next_rdata = multiply_aux_reg;
    end
  end

  // Unmapped addresses still answer, reading zero and dropping writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wb_hit;
      if (wb_hit && !we_i) begin
        dat_o <= {24'h000000, next_rdata};
      end
    end
  end

endmodule
`default_nettype wire

// >>> verification/cie_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cie_core_asserts
  import cie_pkg::*;
#(
  parameter int unsigned ADDR_W = 10
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        exec_valid_i,
  input wire cie_op_t     exec_op_i,
  input wire logic [7:0]  exec_data_i,
  input wire logic [7:0]  exec_aux_i,
  input wire logic        exec_ready_o,
  input wire logic        exec_done_o,
  input wire logic        wr_valid_o,
  input wire logic [7:0]  wr_data_o,
  input wire logic [15:0] pc_o
);
  // Only one operation is in flight, so one set of held operands is enough.
  logic        take;
  cie_op_t     h_op;
  logic [7:0]  h_d;
  logic [7:0]  h_x;
  logic [15:0] h_pc;
  logic [7:0]  dec;
  logic [7:0]  dir_exp;
  logic [15:0] rel;
  assign take = exec_valid_i && exec_ready_o;
  assign dec = h_d - 8'h01;
  assign rel = {{8{h_x[7]}}, h_x};
  assign dir_exp = (h_op == OP_ANL_DIR_I) ? (h_d & h_x) : (h_op == OP_ORL_DIR_I) ? (h_d | h_x) : (h_d ^ h_x);
  always_ff @(posedge clk_i) begin
    if (take) begin
      h_op <= exec_op_i;
      h_d  <= exec_data_i;
      h_x  <= exec_aux_i;
      h_pc <= pc_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_retire;
    exec_ready_o && exec_done_o;
  endsequence
  a_ack_pulse: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("bus access not answered by one ack pulse");
  a_rdata_upper: assert property (dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_reset_quiet: assert property (disable iff (1'h0) rst_i |=> !exec_ready_o && !ack_o && pc_o == 16'h0)
    else $error("outputs active during reset");
  a_ready_release: assert property ($fell(rst_i) |=> exec_ready_o)
    else $error("not ready after reset");
  a_muldiv_four: assert property (take && exec_op_i inside {OP_MUL, OP_DIV} |=> !exec_ready_o [*4] ##1 s_retire)
    else $error("multiply or divide not four cycles");
  a_one_cycle: assert property (take && exec_op_i inside {OP_DA, OP_ANL_A, OP_ANL_DIR_A, OP_ORL_A, OP_ORL_DIR_A,
    OP_XRL_A, OP_XRL_DIR_A, OP_RL, OP_RR, OP_RLC, OP_RRC} |=> !exec_ready_o ##1 s_retire)
    else $error("single cycle operation wrong length");
  a_two_cycle: assert property (take && exec_op_i inside {OP_ANL_DIR_I, OP_ORL_DIR_I, OP_XRL_DIR_I, OP_JMP_ADPTR,
    OP_JBC, OP_DECREMENT_BRANCH_NONZERO, OP_ANL_CNBIT, OP_ORL_CNBIT} |=> !exec_ready_o [*2] ##1 s_retire)
    else $error("two cycle operation wrong length");
  a_dir_write: assert property (take && exec_op_i inside {OP_ANL_DIR_I, OP_ORL_DIR_I, OP_XRL_DIR_I} |->
    ##3 (wr_valid_o && wr_data_o == dir_exp)) else $error("direct write-back wrong");
  a_decrement_branch_nonzero_loop: assert property (take && exec_op_i == OP_DECREMENT_BRANCH_NONZERO |-> ##3 (wr_valid_o && wr_data_o == dec
    && pc_o == h_pc + 16'h0002 + ((dec != 8'h00) ? rel : 16'h0000))) else $error("decrement branch wrong");
  a_jbc_branch: assert property (take && exec_op_i == OP_JBC |-> ##3 (wr_valid_o == h_d[0]
    && (!h_d[0] || wr_data_o == 8'h00) && pc_o == h_pc + 16'h0003 + (h_d[0] ? rel : 16'h0000)))
    else $error("bit test branch wrong");
endmodule
`default_nettype wire

// >>> verification/tb_cie_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cie_core
  import cie_pkg::*;
;
  logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, wr_seen = 1'h0;
  logic        exec_valid_i = 1'h0, exec_wide_i = 1'h0, ack_o, exec_ready_o, exec_done_o, wr_valid_o;
  logic        carry_flag_o, parity_o, idle_o;
  logic [9:0]  adr_i = 10'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, seed = 32'h8A96;
  cie_op_t     exec_op_i = OP_MUL;
  logic [7:0]  exec_data_i = 8'h0, exec_aux_i = 8'h0, wr_data_o, wr_last;
  logic [15:0] pc_o;
  int          mismatches = 0;
  int          n_compared = 0;

  cie_core #(.ADDR_W(10)) dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .exec_valid_i, .exec_op_i, .exec_data_i, .exec_aux_i, .exec_wide_i, .exec_ready_o, .exec_done_o,
    .wr_valid_o, .wr_data_o, .pc_o, .carry_flag_o, .parity_o, .idle_o);

  always #4 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (wr_valid_o === 1'h1) begin
      wr_seen <= 1'h1;
      wr_last <= wr_data_o;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ******************************************************
  // Expected result: {write valid, write data, A, B, carry, overflow}.
  // ******************************************************
  function automatic logic [26:0] model(cie_op_t op, logic [7:0] a, b, d, x, logic cy, ac, ov);
    logic [15:0] p;
    logic [8:0]  t;
    logic        wv;
    logic [7:0]  w;
    p = a * b;
    t = {1'h0, a};
    wv = 1'h0;
    w = 8'h0;
    case (op)
      OP_MUL: {a, b, cy, ov} = {p[7:0], p[15:8], 1'h0, p[15:8] != 8'h0};
      OP_DIV: {a, b, cy, ov} = (b == 8'h0) ? {a, b, 2'h1} : {a / b, a % b, 2'h0};
      OP_DA: begin
        if (t[3:0] > 4'h9 || ac) t = t + 9'h006;
        if (t[7:4] > 4'h9 || cy || t[8]) t = t + 9'h060;
        {cy, a} = {cy | t[8], t[7:0]};
      end
      OP_ANL_A: a = a & d;
      OP_ORL_A: a = a | d;
      OP_XRL_A: a = a ^ d;
      OP_ANL_DIR_A, OP_ANL_DIR_I: {wv, w} = {1'h1, d & ((op == OP_ANL_DIR_A) ? a : x)};
      OP_ORL_DIR_A, OP_ORL_DIR_I: {wv, w} = {1'h1, d | ((op == OP_ORL_DIR_A) ? a : x)};
      OP_XRL_DIR_A, OP_XRL_DIR_I: {wv, w} = {1'h1, d ^ ((op == OP_XRL_DIR_A) ? a : x)};
      OP_RL: a = {a[6:0], a[7]};
      OP_RR: a = {a[0], a[7:1]};
      OP_RLC: {cy, a} = {a, cy};
      OP_RRC: {a, cy} = {cy, a};
      OP_ANL_CNBIT: cy = cy & ~d[0];
      OP_ORL_CNBIT: cy = cy | ~d[0];
      default: ;
    endcase
    return {wv, w, a, b, cy, ov};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i} <= {2'h3, wr, 4'h1};
    adr_i <= {idx, 2'h0};
    dat_i <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 40);
    rd = dat_o[7:0];
    {cyc_i, stb_i} <= 2'h0;
    dat_i <= ~dat_i;
    chk("ack_o", 16'h1, {15'h0, ack_o});
  endtask

  // The request is held until ready is seen, so a busy core can never drop it.
  task automatic run(input cie_op_t op, input logic [7:0] d, x, input logic w);
    int n;
    @(posedge clk_i);
    exec_valid_i <= 1'h1;
    exec_op_i    <= op;
    exec_data_i  <= d;
    exec_aux_i   <= x;
    exec_wide_i  <= w;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (exec_ready_o !== 1'h1 && n < 40);
    {exec_valid_i, exec_data_i} <= {1'h0, ~d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (exec_done_o !== 1'h1 && n < 40);
    chk("exec_done_o", 16'h1, {15'h0, exec_done_o});
  endtask

  initial begin
    logic [7:0]  idx [7] = '{REG_STACK_PTR, REG_DATA_POINTER_LOW, REG_DATA_POINTER_HIGH, REG_IDLE_SEL, REG_MAIN_WORK, REG_MUL_AUX, 8'h10};
    logic [7:0]  v [7];
    logic [7:0]  a, b, d, x, r;
    logic [31:0] q;
    logic [26:0] e;
    logic        cy, ac, ov;
    cie_op_t     op;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 7; i++) begin
      wb(1'h0, idx[i], 8'h0, r);
      chk("reset_value", (i == 0) ? RST_STACK_PTR : RST_ZERO, r);
      q = rnd();
      v[i] = (i == 6) ? 8'h0 : q[7:0];
      wb(1'h1, idx[i], q[7:0], r);
      wb(1'h0, idx[i], 8'h0, r);
      chk("readback", v[i], r);
    end
    chk("idle_o", v[3][0], idle_o);
    wb(1'h1, REG_IDLE_SEL, 8'h0, r);
    for (int i = 0; i < 70; i++) begin
      {a, b, d, x} = rnd();
      q = rnd();
      {cy, ac, ov} = q[2:0];
      op = cie_op_t'(q[12:8] % 5'd21);
      case (i)
        0: begin
          op = OP_DIV;
          b = 8'h00;
        end
        1: begin
          op = OP_MUL;
          {a, b} = 16'hFFFF;
        end
        2: begin
          op = OP_DA;
          {a, cy, ac} = {8'h9A, 2'h0};
        end
        default: ;
      endcase
      wb(1'h1, REG_MAIN_WORK, a, r);
      wb(1'h1, REG_MUL_AUX, b, r);
      // Parity is written inverted on purpose: the bit must not take bus writes.
      wb(1'h1, REG_STATUS, {cy, ac, 3'h0, ov, 1'h0, ~^a}, r);
      e = model(op, a, b, d, x, cy, ac, ov);
      wr_seen = 1'h0;
      run(op, d, x, q[3]);
      wb(1'h0, REG_MAIN_WORK, 8'h0, r);
      chk("main_working_reg", e[17:10], r);
      wb(1'h0, REG_MUL_AUX, 8'h0, r);
      chk("multiply_aux_reg", e[9:2], r);
      wb(1'h0, REG_STATUS, 8'h0, r);
      chk("status", {e[1], ac, e[0], ^e[17:10]}, {r[7], r[6], r[2], r[0]});
      chk("carry_flag_o", e[1], carry_flag_o);
      chk("parity_o", ^e[17:10], parity_o);
      if (e[26]) chk("wr_data_o", {7'h1, e[25:18]}, {wr_seen, wr_last});
      if (op == OP_JMP_ADPTR) chk("pc_o", {8'h0, a} + {v[2], v[1]}, pc_o);
    end
    end_of_test();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    chk("watchdog", 16'h0, 16'h1);
    end_of_test();
  end
endmodule

bind cie_core cie_core_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
  .exec_valid_i, .exec_op_i, .exec_data_i, .exec_aux_i, .exec_ready_o, .exec_done_o, .wr_valid_o, .wr_data_o, .pc_o);
`default_nettype wire
